// >>> common/evt_report_defs.svh
/*
  Register offsets, field positions and reset values of the event-reporting block.
  Assumes inclusion by bare name from any file that needs them.
*/
`ifndef EVT_REPORT_DEFS_SVH
`define EVT_REPORT_DEFS_SVH

`define RISE_MASK_WR_ADDR 8'h0D
`define RISE_MASK_SET_ADDR 8'h0E
`define RISE_MASK_CLR_ADDR 8'h0F
`define FALL_MASK_WR_ADDR 8'h10
`define FALL_MASK_SET_ADDR 8'h11
`define FALL_MASK_CLR_ADDR 8'h12
`define LIVE_SRC_ADDR 8'h13
`define CAPTURED_ADDR 8'h14
`define LINE_VIEW_ADDR 8'h15

`define SRC_BIT_DETACH 0
`define SRC_BIT_POWER 1
`define SRC_BIT_SESSION 2
`define SRC_BIT_END 3
`define SRC_BIT_ID 4
`define SRC_COUNT 5

`define MASK_RESET_VAL 8'h1F
`define CAPTURED_RESET_VAL 8'h00
`define READ_UNMAPPED_VAL 8'h00

`endif

// >>> common/evt_report_pkg.sv
/*
  Types shared by the event-reporting block.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package evt_report_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    ACC_READ,
    ACC_WRITE,
    ACC_SET,
    ACC_CLEAR
  } access_kind_t;
endpackage
`default_nettype wire

// >>> rtl/usb_phy_event_reporting.sv
/*
  Event-reporting logic of a low-pin-interface USB transceiver: edge masks,
  live status view, read-to-clear capture register, line-state view and
  receive-command byte request.
  Assumes the register access engine presents one access per cycle, all
  inputs synchronous to CLK.
*/
// Functional notes
// - unmasked rising source edge raises interrupt and requests a receive-command byte.
// - unmasked falling source edge raises interrupt and requests a receive-command byte.
// - both masks reset to 1Fh; bits 7 to 5 reserved, zero.
// - bit 4 id, 3 session end, 2 session valid, 1 power, 0 detach.
// - rising mask read/write at 0Dh, set at 0Eh, clear at 0Fh.
// - falling mask read/write at 10h, set at 11h, clear at 12h.
// - status at 13h is read-only and shows live source values.
// - status bits come from detector and comparator outputs in mapped order.
// - allowed transitions set capture bits; masked transitions do not.
// - reading capture register clears it and returns the prior value.
// - entering low-power mode clears the capture register, except for edges that hit in that same cycle.
// - capture register read-only, resets to zero, bits 7 to 5 zero.
// - debug register at 15h shows line state in bits 1:0, rest zero.
`timescale 1ns/10ps
`default_nettype none
`include "evt_report_defs.svh"

module usb_phy_event_reporting #(
  parameter int SRC_W = `SRC_COUNT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register access from the link
  input wire logic REG_REQ,
  input wire evt_report_pkg::access_kind_t REG_KIND,
  input wire logic [7:0] REG_ADDR,
  input wire evt_report_pkg::reg_byte_t REG_WDATA,
  output evt_report_pkg::reg_byte_t REG_RDATA,
  output logic REG_RVALID,
  // event sources
  input wire logic ID_GROUNDED,
  input wire logic SESSION_ENDED,
  input wire logic SESSION_OK_CMP,
  input wire logic BUS_POWER_OK_CMP,
  input wire logic DOWNSTREAM_DETACH,
  input wire logic LINE_CONDITION_HI,
  input wire logic LINE_CONDITION_LO,
  input wire logic LOW_POWER_MODE,
  // event reporting toward the link
  output logic EVENT_IRQ,
  output logic RXCMD_REQ,
  output evt_report_pkg::reg_byte_t RXCMD_STATUS
);
  import evt_report_pkg::*;

  // the bit map is fixed by the register layout, so no other width can be served
  if (SRC_W != `SRC_COUNT) begin : g_bad_src_w
    $error("SRC_W must equal the number of event sources");
  end

  localparam reg_byte_t CAPT_RST = `CAPTURED_RESET_VAL;

  reg_byte_t rise_mask_ff, nxt_rise_mask;
  reg_byte_t fall_mask_ff, nxt_fall_mask;
  logic [SRC_W-1:0] src_prev_ff;
  logic [SRC_W-1:0] captured_ff, nxt_captured;
  logic low_power_prev_ff;
  logic [SRC_W-1:0] rise_hit, fall_hit;
  logic [SRC_W-1:0] live_src;

  // one fixed bit per source, shared by masks, status and captures
  assign live_src[`SRC_BIT_ID] = ID_GROUNDED;
  assign live_src[`SRC_BIT_END] = SESSION_ENDED;
  assign live_src[`SRC_BIT_SESSION] = SESSION_OK_CMP;
  assign live_src[`SRC_BIT_POWER] = BUS_POWER_OK_CMP;
  assign live_src[`SRC_BIT_DETACH] = DOWNSTREAM_DETACH;

  wire reg_byte_t live_byte = {{(8 - SRC_W){1'b0}}, live_src};
  wire reg_byte_t captured_byte = {{(8 - SRC_W){1'b0}}, captured_ff};
  wire reg_byte_t line_byte = {6'h00, LINE_CONDITION_HI, LINE_CONDITION_LO};
  wire reg_byte_t field_mask = `MASK_RESET_VAL;

  // a kind at the wrong address of a triple falls through and is ignored
  wire logic is_wr = REG_REQ && (REG_KIND == ACC_WRITE);
  wire logic is_set = REG_REQ && (REG_KIND == ACC_SET);
  wire logic is_clr = REG_REQ && (REG_KIND == ACC_CLEAR);
  wire logic is_rd = REG_REQ && (REG_KIND == ACC_READ);

  wire logic rise_wr = is_wr && (REG_ADDR == `RISE_MASK_WR_ADDR);
  wire logic rise_set = is_set && (REG_ADDR == `RISE_MASK_SET_ADDR);
  wire logic rise_clr = is_clr && (REG_ADDR == `RISE_MASK_CLR_ADDR);
  wire logic fall_wr = is_wr && (REG_ADDR == `FALL_MASK_WR_ADDR);
  wire logic fall_set = is_set && (REG_ADDR == `FALL_MASK_SET_ADDR);
  wire logic fall_clr = is_clr && (REG_ADDR == `FALL_MASK_CLR_ADDR);

  // any address of a mask's triple reads that mask
  wire logic rd_rise = (REG_ADDR >= `RISE_MASK_WR_ADDR) && (REG_ADDR <= `RISE_MASK_CLR_ADDR);
  wire logic rd_fall = (REG_ADDR >= `FALL_MASK_WR_ADDR) && (REG_ADDR <= `FALL_MASK_CLR_ADDR);
  wire logic rd_capt = is_rd && (REG_ADDR == `CAPTURED_ADDR);

  wire reg_byte_t rd_mux =
    rd_rise ? rise_mask_ff :
    rd_fall ? fall_mask_ff :
    (REG_ADDR == `LIVE_SRC_ADDR) ? live_byte :
    (REG_ADDR == `CAPTURED_ADDR) ? captured_byte :
    (REG_ADDR == `LINE_VIEW_ADDR) ? line_byte :
    `READ_UNMAPPED_VAL;

  // reserved mask bits stay zero whatever the link writes
  assign nxt_rise_mask = field_mask & (rise_wr ? REG_WDATA :
                                       rise_set ? (rise_mask_ff | REG_WDATA) :
                                       rise_clr ? (rise_mask_ff & ~REG_WDATA) :
                                       rise_mask_ff);
  assign nxt_fall_mask = field_mask & (fall_wr ? REG_WDATA :
                                       fall_set ? (fall_mask_ff | REG_WDATA) :
                                       fall_clr ? (fall_mask_ff & ~REG_WDATA) :
                                       fall_mask_ff);

  genvar g;
  generate
    for (g = 0; g < SRC_W; g++) begin : g_edge
      assign rise_hit[g] = live_src[g] && !src_prev_ff[g] && rise_mask_ff[g];
      assign fall_hit[g] = !live_src[g] && src_prev_ff[g] && fall_mask_ff[g];
    end
  endgenerate

  // each edge is judged on its own mask; rises and falls share one capture bit
  wire logic [SRC_W-1:0] any_hit = rise_hit | fall_hit;
  wire logic lp_entry = LOW_POWER_MODE && !low_power_prev_ff;

  // new events win over a read clear so none is lost
  assign nxt_captured = ((rd_capt || lp_entry) ? '0 : captured_ff) | any_hit;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rise_mask_ff <= `MASK_RESET_VAL;
    end else begin
      rise_mask_ff <= nxt_rise_mask;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fall_mask_ff <= `MASK_RESET_VAL;
    end else begin
      fall_mask_ff <= nxt_fall_mask;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      captured_ff <= CAPT_RST[SRC_W-1:0];
    end else begin
      captured_ff <= nxt_captured;
    end
  end

  // previous sample starts at zero, so a source high at reset reports a rise
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_prev_ff <= '0;
    end else begin
      src_prev_ff <= live_src;
    end
  end

  // a level already high at reset counts as an entry and clears captures once
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_power_prev_ff <= 1'b0;
    end else begin
      low_power_prev_ff <= LOW_POWER_MODE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= is_rd;
    end
  end

  // read data holds between reads so the link may pick it up late
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= '0;
    end else begin
      if (is_rd) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

  // one request per cycle with a hit; the link sees the post-transition status
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EVENT_IRQ <= 1'b0;
    end else begin
      EVENT_IRQ <= |any_hit;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RXCMD_REQ <= 1'b0;
    end else begin
      RXCMD_REQ <= |any_hit;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RXCMD_STATUS <= '0;
    end else begin
      if (|any_hit) begin
        RXCMD_STATUS <= live_byte;
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/usb_phy_event_reporting_checker.sv
/* Port checker for the event-reporting block.
   Assumes the bind at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module usb_phy_event_reporting_checker (
  // watched ports
  input wire logic CLK,
  input wire logic RST_N,
  // register access
  input wire logic REG_REQ,
  input wire evt_report_pkg::access_kind_t REG_KIND,
  input wire logic [7:0] REG_ADDR,
  input wire evt_report_pkg::reg_byte_t REG_RDATA,
  input wire logic REG_RVALID,
  // sources
  input wire logic ID_GROUNDED,
  input wire logic SESSION_ENDED,
  input wire logic SESSION_OK_CMP,
  input wire logic BUS_POWER_OK_CMP,
  input wire logic DOWNSTREAM_DETACH,
  input wire logic LINE_CONDITION_HI,
  input wire logic LINE_CONDITION_LO,
  input wire logic LOW_POWER_MODE,
  // reporting
  input wire logic EVENT_IRQ,
  input wire logic RXCMD_REQ,
  input wire evt_report_pkg::reg_byte_t RXCMD_STATUS
);
  import evt_report_pkg::*;
  wire [4:0] src = {ID_GROUNDED, SESSION_ENDED, SESSION_OK_CMP, BUS_POWER_OK_CMP,
    DOWNSTREAM_DETACH};
  wire rd = REG_REQ && REG_KIND == ACC_READ;
  wire rd14 = rd && REG_ADDR == 8'h14;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_rv; rd |=> REG_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("no read valid");
  property p_live; rd && REG_ADDR == 8'h13 |=> REG_RDATA == {3'h0, $past(src)}; endproperty
  a_live: assert property (p_live) else $error("bad status");
  property p_line; rd && REG_ADDR == 8'h15 |=> REG_RDATA == {6'h00, $past(LINE_CONDITION_HI),
    $past(LINE_CONDITION_LO)}; endproperty
  a_line: assert property (p_line) else $error("bad line view");
  property p_pair; EVENT_IRQ == RXCMD_REQ; endproperty
  a_pair: assert property (p_pair) else $error("irq without byte");
  property p_stat; RXCMD_REQ |-> RXCMD_STATUS[4:0] == $past(src); endproperty
  a_stat: assert property (p_stat) else $error("stale byte");
  // guard on reset: the edge sampler restarts from zero
  property p_quiet; $past(RST_N) && $stable(src) |=> !EVENT_IRQ; endproperty
  a_quiet: assert property (p_quiet) else $error("event without edge");
  property p_clr; $past(RST_N) && rd14 && $stable(src) ##1 $stable(src) ##1 rd14 && $stable(src)
    |=> REG_RDATA == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("capture not cleared");
  property p_lp; $past(RST_N) && $rose(LOW_POWER_MODE) && $stable(src) ##1 rd14 && $stable(src)
    |=> REG_RDATA == 8'h00; endproperty
  a_lp: assert property (p_lp) else $error("low power kept captures");
  c_irq: cover property (EVENT_IRQ);
  c_lp: cover property ($rose(LOW_POWER_MODE));
  c_rd2: cover property (rd14 ##2 rd14);
endmodule
bind usb_phy_event_reporting usb_phy_event_reporting_checker chk_u (.*);
`default_nettype wire

// >>> sim/usb_link_model.sv
/* Link-side sink of receive-command bytes.
   Assumes one RXCMD_REQ pulse per byte. */
`timescale 1ns/10ps
`default_nettype none
module usb_link_model (
  // clock and bytes in
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RXCMD_REQ,
  input wire evt_report_pkg::reg_byte_t RXCMD_STATUS,
  // what the link saw
  output var int cmd_count,
  output evt_report_pkg::reg_byte_t last_cmd
);
  import evt_report_pkg::*;
  // bytes carry every unmasked change, so the latch is never read here
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_count <= 0;
      last_cmd <= 8'h00;
    end else if (RXCMD_REQ) begin
      cmd_count <= cmd_count + 1;
      last_cmd <= RXCMD_STATUS;
    end
  end
endmodule
`default_nettype wire

// >>> sim/usb_phy_event_reporting_tb_top.sv
/* Self-checking bench of the event-reporting block.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
`default_nettype none
module usb_phy_event_reporting_tb_top;
  import evt_report_pkg::*;
  logic clk = 0, rst_n = 0, req = 0, lpm = 0, rvalid, irq, rx_req;
  logic [1:0] line = 0;
  logic [4:0] src = 0;
  logic [7:0] addr = 0;
  access_kind_t kind = ACC_READ;
  reg_byte_t wdata = 0, rdata, rx_stat, last_cmd;
  int fails = 0, comparisons = 0, cmd_count;
  always #2 clk = ~clk;
  usb_phy_event_reporting dut_u (.CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_KIND(kind),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .ID_GROUNDED(src[4]), .SESSION_ENDED(src[3]), .SESSION_OK_CMP(src[2]),
    .BUS_POWER_OK_CMP(src[1]), .DOWNSTREAM_DETACH(src[0]), .LINE_CONDITION_HI(line[1]),
    .LINE_CONDITION_LO(line[0]), .LOW_POWER_MODE(lpm), .EVENT_IRQ(irq), .RXCMD_REQ(rx_req),
    .RXCMD_STATUS(rx_stat));
  usb_link_model link_u (.CLK(clk), .RST_N(rst_n), .RXCMD_REQ(rx_req),
    .RXCMD_STATUS(rx_stat), .cmd_count(cmd_count), .last_cmd(last_cmd));
  task automatic chk(input logic ok, input reg_byte_t got);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: got %h", $time, got);
    end
  endtask
  // for reads d is the expected byte
  task automatic acc(input access_kind_t k, input logic [7:0] a, input reg_byte_t d);
    @(negedge clk);
    kind = k;
    addr = a;
    wdata = d;
    req = 1'b1;
    @(negedge clk);
    req = 0;
    if (k == ACC_READ) chk(rvalid === 1'b1 && rdata === d, rdata);
  endtask
  task automatic ev(input logic [4:0] v, input reg_byte_t cap, input int n);
    src = v;
    repeat (2) @(negedge clk);
    chk(cmd_count == n && (n == 0 || last_cmd[4:0] === v), last_cmd);
    acc(ACC_READ, 8'h14, cap);
  endtask
  task automatic end_of_test;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    acc(ACC_READ, 8'h0D, 8'h1F);
    acc(ACC_READ, 8'h10, 8'h1F);
    acc(ACC_READ, 8'h14, 8'h00);
    for (int b = 8'h0D; b <= 8'h10; b += 3) begin
      acc(ACC_WRITE, b[7:0], 8'hFF);
      acc(ACC_READ, b[7:0], 8'h1F);
      acc(ACC_WRITE, b[7:0], 8'h0A);
      acc(ACC_SET, b[7:0] + 8'h01, 8'h11);
      acc(ACC_READ, b[7:0] + 8'h02, 8'h1B);
      acc(ACC_CLEAR, b[7:0] + 8'h02, 8'h03);
      acc(ACC_READ, b[7:0] + 8'h01, 8'h18);
    end
    acc(ACC_WRITE, 8'h0D, 8'h15);
    acc(ACC_WRITE, 8'h10, 8'h0A);
    acc(ACC_WRITE, 8'h13, 8'hFF);
    ev(5'h02, 8'h00, 0);
    ev(5'h1F, 8'h15, 1);
    acc(ACC_READ, 8'h13, 8'h1F);
    ev(5'h00, 8'h0A, 2);
    acc(ACC_READ, 8'h14, 8'h00);
    acc(ACC_READ, 8'h16, 8'h00);
    src = 5'h1F;
    repeat (2) @(negedge clk);
    lpm = 1;
    acc(ACC_READ, 8'h14, 8'h00);
    for (int i = 1; i <= 2; i++) begin
      line = i[1:0];
      acc(ACC_READ, 8'h15, {6'h00, i[1:0]});
    end
    end_of_test();
  end
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
